// ### design/region_protection_unit.sv
// Region protection unit: register file and access checker.
`timescale 1ns/100ps
module region_protection_unit
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  input wire region_protection_pkg::access_t access_in,
  output region_protection_pkg::verdict_t verdict_out,
  output logic verdict_valid_out
);
  import region_protection_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t state_reg;
  state_t state_next;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // Offsets are decoded once so that the write and read paths agree on which
  // registers exist; an unmapped offset matches nothing and is ignored.
  logic wr_control;
  logic wr_select;
  logic wr_base;
  logic wr_attr;

  logic rd_type;
  logic rd_control;
  logic rd_select;
  logic rd_base;
  logic rd_attr;

  logic [2:0] sel_index;
  logic base_retarget;
  logic [2:0] base_index;
  logic [23:0] base_field;
  logic [31:0] attr_field;
  logic [2:0] control_field;
  logic [3:0] select_field;

  assign wr_control = reg_write_in && (reg_addr_in == OFF_CONTROL);
  assign wr_select = reg_write_in && (reg_addr_in == OFF_SELECT);
  assign wr_base = reg_write_in && (reg_addr_in == OFF_BASE);
  assign wr_attr = reg_write_in && (reg_addr_in == OFF_ATTR);
  assign rd_type = reg_read_in && (reg_addr_in == OFF_TYPE);
  assign rd_control = reg_read_in && (reg_addr_in == OFF_CONTROL);
  assign rd_select = reg_read_in && (reg_addr_in == OFF_SELECT);
  assign rd_base = reg_read_in && (reg_addr_in == OFF_BASE);
  assign rd_attr = reg_read_in && (reg_addr_in == OFF_ATTR);

  // Only the low three bits index a region; bit 3 is kept for read-back.
  assign sel_index = state_reg.select[2:0];
  assign base_retarget = reg_wdata_in[BASE_VALID_BIT];
  assign base_index = base_retarget ? reg_wdata_in[2:0] : sel_index;
  assign base_field = reg_wdata_in[31:BASE_ADDR_LSB];
  assign attr_field = reg_wdata_in & ATTR_WRITE_MASK;
  assign control_field = reg_wdata_in[2:0];
  assign select_field = reg_wdata_in[3:0];

  // ---------------------------------------------------------------
  // Access view
  // ---------------------------------------------------------------
  logic [31:0] acc_addr;
  logic acc_privileged;
  logic acc_fetch;
  logic acc_handler;

  assign acc_addr = access_in.addr;
  assign acc_privileged = access_in.privileged;
  assign acc_fetch = access_in.fetch;
  assign acc_handler = access_in.fault_handler;
  // The write flag travels with the access but needs no decision here, as
  // permissions are reported rather than enforced.

  // ---------------------------------------------------------------
  // Control view
  // ---------------------------------------------------------------
  logic unit_enable;
  logic background_map_enable;
  logic fault_handler_protect_enable;

  // Software is trusted not to set handler protection while the unit is off.
  assign unit_enable = state_reg.control[CTRL_ENABLE_BIT];
  assign background_map_enable = state_reg.control[CTRL_PRIVDEF_BIT];
  assign fault_handler_protect_enable = state_reg.control[CTRL_HFNMI_BIT];

  // ---------------------------------------------------------------
  // Read words
  // ---------------------------------------------------------------
  logic [7:0] instr_region_count;
  logic [7:0] data_region_count;
  logic separate_maps;
  logic [23:0] selected_base;
  logic [31:0] selected_attr;
  logic [31:0] type_word;
  logic [31:0] control_word;
  logic [31:0] select_word;
  logic [31:0] base_word_rd;
  logic [31:0] attr_word;
  logic [31:0] read_word;

  // Only one unified map exists, so the instruction count and flag are zero.
  assign instr_region_count = 8'h00;
  assign data_region_count = DATA_REGION_COUNT;
  assign separate_maps = 1'b0;
  assign type_word = {8'h00, instr_region_count, data_region_count, 7'h00,
    separate_maps};
  assign control_word = {29'h0000_0000, state_reg.control};
  assign select_word = {28'h000_0000, state_reg.select};
  assign selected_base = state_reg.regions[sel_index].base;
  assign selected_attr = state_reg.regions[sel_index].attr;
  // The valid bit and bits 7:5 always read as zero.
  assign base_word_rd = {selected_base, 4'h0, state_reg.select};
  assign attr_word = selected_attr;

  always_comb
  begin
    read_word = ZERO_WORD;
    if (rd_type)
    begin
      read_word = type_word;
    end
    else if (rd_control)
    begin
      read_word = control_word;
    end
    else if (rd_select)
    begin
      read_word = select_word;
    end
    else if (rd_base)
    begin
      read_word = base_word_rd;
    end
    else if (rd_attr)
    begin
      read_word = attr_word;
    end
  end

  // ---------------------------------------------------------------
  // Region matching
  // ---------------------------------------------------------------
  // A region only counts when enabled and its subregion is not masked off.
  // Sizes below the legal minimum are treated as the minimum so that the
  // subregion slice stays meaningful; software is expected not to write them.
  logic [REGION_COUNT-1:0] hit_vec;

  for (genvar g = 0; g < REGION_COUNT; g++)
  begin : g_region
    logic enabled;
    logic [4:0] size_raw;
    logic [4:0] size_eff;
    logic [31:0] span_mask;
    logic [31:0] base_word;
    logic [31:0] offset;
    logic base_match;
    logic [4:0] sub_shift;
    logic [2:0] sub_index;
    logic [7:0] sub_mask;
    logic sub_off;

    assign enabled = state_reg.regions[g].attr[ATTR_ENABLE_BIT];
    assign size_raw = state_reg.regions[g].attr[ATTR_SIZE_LSB +: 5];
    assign size_eff = (size_raw < MIN_SIZE) ? MIN_SIZE : size_raw;
    // The full-map size would shift the carry out of the word, so it is
    // spelled out rather than computed.
    assign span_mask = (size_eff == 5'h1f) ? 32'hffff_ffff
      : ((32'h0000_0002 << size_eff) - 32'h0000_0001);
    assign base_word = {state_reg.regions[g].base, 8'h00};
    assign offset = acc_addr & span_mask;
    assign base_match = (acc_addr & ~span_mask) == (base_word & ~span_mask);
    assign sub_shift = size_eff - 5'h02;
    assign sub_index = 3'(offset >> sub_shift);
    assign sub_mask = state_reg.regions[g].attr[ATTR_SRD_LSB +: 8];
    assign sub_off = sub_mask[sub_index];
    assign hit_vec[g] = enabled && base_match && !sub_off;
  end

  // ---------------------------------------------------------------
  // Region priority
  // ---------------------------------------------------------------
  // The highest numbered matching region wins, so a later region can carve
  // an exception out of an earlier, larger one.
  logic any_hit;
  logic [2:0] top;

  always_comb
  begin
    any_hit = 1'b0;
    top = 3'h0;
    for (int i = 0; i < REGION_COUNT; i++)
    begin
      if (hit_vec[i])
      begin
        any_hit = 1'b1;
        top = 3'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Access decision
  // ---------------------------------------------------------------
  region_t top_region;
  logic [2:0] top_permission;
  logic top_no_execute;
  logic [2:0] top_scb;
  logic handler_bypass;
  logic checking;
  logic background_ok;
  logic fetch_blocked;
  verdict_t verdict_calc;

  assign top_region = state_reg.regions[top];
  assign top_permission = top_region.attr[26:24];
  assign top_no_execute = top_region.attr[ATTR_XN_BIT];
  assign top_scb = top_region.attr[18:16];
  // Protection is suspended in fault handlers unless the protect bit is set.
  assign handler_bypass = acc_handler && !fault_handler_protect_enable;
  assign checking = unit_enable && !handler_bypass;
  // The background map is only looked at once checking is on, so the bit
  // has no effect while the unit is disabled.
  assign background_ok = acc_privileged && background_map_enable;
  assign fetch_blocked = acc_fetch && top_no_execute;

  // Region number and attributes mean something only beside the hit flag.
  always_comb
  begin
    verdict_calc = '0;
    if (!checking)
    begin
      verdict_calc.background = 1'b1;
    end
    else if (any_hit)
    begin
      verdict_calc.hit = 1'b1;
      verdict_calc.region = top;
      verdict_calc.permission = top_permission;
      verdict_calc.no_execute = top_no_execute;
      verdict_calc.scb = top_scb;
      verdict_calc.fault = fetch_blocked;
    end
    else if (background_ok)
    begin
      verdict_calc.background = 1'b1;
    end
    else
    begin
      verdict_calc.fault = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // The strobes come from one offset, so at most one strobe is active
  // in any cycle and the order of the branches below does not matter.
  always_comb
  begin
    state_next = state_reg;
    if (wr_control)
    begin
      state_next.control = control_field;
    end
    if (wr_select)
    begin
      state_next.select = select_field;
    end
    // A retargeting base write moves the select and the base at one edge.
    if (wr_base)
    begin
      if (base_retarget)
      begin
        state_next.select = select_field;
      end
      state_next.regions[base_index].base = base_field;
    end
    if (wr_attr)
    begin
      state_next.regions[sel_index].attr = attr_field;
    end
    // Read data stand for one cycle only and are zero otherwise.
    state_next.rdata = read_word;
    state_next.verdict = verdict_calc;
    state_next.valid = access_in.valid;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset clears every region, so the unit starts disabled with all regions off.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output comes straight from a flip-flop, so none of them glitches.
  assign reg_rdata_out = state_reg.rdata;
  assign verdict_out = state_reg.verdict;
  assign verdict_valid_out = state_reg.valid;

endmodule : region_protection_unit

// ### pkg/region_protection_pkg.sv
// Constants, field positions and carrier types for the region protection unit.
package region_protection_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] OFF_TYPE = 16'hed90;
  localparam logic [15:0] OFF_CONTROL = 16'hed94;
  localparam logic [15:0] OFF_SELECT = 16'hed98;
  localparam logic [15:0] OFF_BASE = 16'hed9c;
  localparam logic [15:0] OFF_ATTR = 16'heda0;

  // ---------------------------------------------------------------
  // Geometry and field positions
  // ---------------------------------------------------------------
  localparam int REGION_COUNT = 8;
  localparam logic [7:0] DATA_REGION_COUNT = 8'h08;
  localparam int DREG_LSB = 8;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HFNMI_BIT = 1;
  localparam int CTRL_PRIVDEF_BIT = 2;
  localparam int BASE_VALID_BIT = 4;
  localparam int BASE_ADDR_LSB = 8;
  localparam int ATTR_ENABLE_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_SRD_LSB = 8;
  localparam int ATTR_XN_BIT = 28;
  localparam logic [4:0] MIN_SIZE = 5'h07;
  localparam logic [31:0] ATTR_WRITE_MASK = 32'h1707_ff3f;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [23:0] base;
    logic [31:0] attr;
  } region_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic privileged;
    logic fetch;
    logic write;
    logic fault_handler;
  } access_t;

  typedef struct packed {
    logic fault;
    logic hit;
    logic [2:0] region;
    logic background;
    logic [2:0] permission;
    logic no_execute;
    logic [2:0] scb;
  } verdict_t;

  typedef struct packed {
    logic [2:0] control;
    logic [3:0] select;
    region_t [REGION_COUNT-1:0] regions;
    logic [31:0] rdata;
    verdict_t verdict;
    logic valid;
  } state_t;

endpackage : region_protection_pkg

// ### tb/core_access_model.sv
// Processor core model issuing accesses.
`timescale 1ns/100ps
module core_access_model
(
  input wire logic clock_in,
  output region_protection_pkg::access_t access_out
);
  import region_protection_pkg::*;
  initial access_out = '0;
  // The address is inverted when idle so a stale value is never trusted.
  task issue(input logic [31:0] a, input logic [2:0] pfh);
  begin
    @(posedge clock_in);
    access_out <= {1'b1, a, pfh[2:1], 1'b0, pfh[0]};
    @(posedge clock_in);
    access_out <= {1'b0, ~a, 4'h0};
  end
  endtask : issue
endmodule : core_access_model

// ### tb/region_protection_unit_sva.sv
// Assertions on the ports of the region protection unit.
`timescale 1ns/100ps
module region_protection_unit_sva
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire region_protection_pkg::access_t access_in,
  input wire region_protection_pkg::verdict_t verdict_out,
  input wire logic verdict_valid_out
);
  import region_protection_pkg::*;
  logic [2:0] ctl_reg;
  logic [3:0] sel_reg;
  // Shadows of control and select as software last wrote them.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctl_reg <= '0;
      sel_reg <= '0;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == OFF_CONTROL)
        ctl_reg <= reg_wdata_in[2:0];
      if (reg_addr_in == OFF_SELECT || (reg_addr_in == OFF_BASE && reg_wdata_in[4]))
        sel_reg <= reg_wdata_in[3:0];
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence rd_at(logic [15:0] a);
    reg_read_in && reg_addr_in == a;
  endsequence
  AST_TYPE: assert property (rd_at(OFF_TYPE)
    |=> reg_rdata_out == 32'h0000_0800) else $error("type word wrong");
  AST_SELECT: assert property (rd_at(OFF_SELECT)
    |=> reg_rdata_out == {28'h0, sel_reg}) else $error("select wrong");
  AST_BASE_LOW: assert property (rd_at(OFF_BASE)
    |=> reg_rdata_out[7:0] == {4'h0, sel_reg}) else $error("base low bits wrong");
  AST_OFF: assert property (access_in.valid && !ctl_reg[0]
    |=> verdict_out.background && !verdict_out.fault) else $error("disabled verdict wrong");
  AST_MISS: assert property (access_in.valid && ctl_reg == 3'h1 ##1 !verdict_out.hit
    |-> verdict_out.fault || verdict_out.background) else $error("miss not faulted");
  AST_BACK: assert property (access_in.valid && ctl_reg == 3'h5 && access_in.privileged
    |=> verdict_out.hit ^ verdict_out.background) else $error("background wrong");
  AST_HANDLER: assert property (access_in.valid && ctl_reg == 3'h1 && access_in.fault_handler
    |=> verdict_out.background && !verdict_out.fault) else $error("handler verdict wrong");
  AST_XN: assert property (verdict_valid_out && verdict_out.hit
    |-> verdict_out.fault == ($past(access_in.fetch) && verdict_out.no_execute))
    else $error("fetch fault wrong");
endmodule : region_protection_unit_sva
bind region_protection_unit region_protection_unit_sva region_protection_unit_sva_inst (.*);

// ### tb/region_protection_unit_test.sv
// Register and access-check regression for the region protection unit.
`timescale 1ns/100ps
module region_protection_unit_test;
  import region_protection_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] adr = '0;
  logic [31:0] wd = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdat;
  access_t acc_s;
  verdict_t vrd;
  logic vval;
  int errors = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  region_protection_unit region_protection_unit_inst (.clock_in(clk), .rst_n_in(rst_n),
    .reg_addr_in(adr), .reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re),
    .reg_rdata_out(rdat), .access_in(acc_s), .verdict_out(vrd), .verdict_valid_out(vval));
  core_access_model core_access_model_inst (.clock_in(clk), .access_out(acc_s));
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t: reg %h want %h", $time, got, exp);
    end
  end
  endtask : chk
  // Region number is only meaningful on a hit.
  task chkv(input logic [5:0] exp);
  begin
    n_checks++;
    if ({vrd.fault, vrd.hit, vrd.hit ? vrd.region : 3'h0, vrd.background} !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t: verdict %h want %h", $time, vrd, exp);
    end
  end
  endtask : chkv
  task wr(input logic [15:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    adr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  end
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] exp);
  begin
    @(posedge clk);
    adr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdat, exp);
  end
  endtask : rd
  task acc(input logic [2:0] c, input logic [31:0] a, input logic [2:0] pfh, input logic [5:0] e);
  begin
    wr(OFF_CONTROL, {29'h0, c});
    core_access_model_inst.issue(a, pfh);
    #1;
    chkv(e);
  end
  endtask : acc
  task test_done;
  begin
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask : test_done
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_TYPE, 32'h0000_0800);
    rd(OFF_CONTROL, 32'h0000_0000);
    wr(OFF_SELECT, 32'h0000_0005);
    rd(OFF_SELECT, 32'h0000_0005);
    wr(OFF_BASE, 32'h2000_0003);
    rd(OFF_BASE, 32'h2000_0005);
    wr(OFF_BASE, 32'h1000_0013);
    rd(OFF_SELECT, 32'h0000_0003);
    rd(OFF_BASE, 32'h1000_0003);
    wr(OFF_ATTR, 32'h1307_0211);
    rd(OFF_ATTR, 32'h1307_0211);
    wr(OFF_SELECT, 32'h0000_0005);
    rd(OFF_ATTR, 32'h0000_0000);
    rd(16'hed84, 32'h0000_0000);
    $display("register test done");
    acc(3'h0, 32'h1000_0000, 3'h0, 6'b000001);
    acc(3'h4, 32'h1000_0000, 3'h0, 6'b000001);
    acc(3'h1, 32'h1000_0000, 3'h0, 6'b010110);
    chk({24'h0, vrd.permission, vrd.no_execute, vrd.scb, vval}, 32'h0000_007f);
    acc(3'h1, 32'h1000_0000, 3'h2, 6'b110110);
    acc(3'h1, 32'h1000_0040, 3'h0, 6'b100000);
    acc(3'h1, 32'h1000_0080, 3'h0, 6'b010110);
    acc(3'h1, 32'h1000_0200, 3'h0, 6'b100000);
    acc(3'h1, 32'h3000_0000, 3'h0, 6'b100000);
    acc(3'h5, 32'h3000_0000, 3'h4, 6'b000001);
    acc(3'h5, 32'h3000_0000, 3'h0, 6'b100000);
    acc(3'h5, 32'h1000_0000, 3'h4, 6'b010110);
    acc(3'h1, 32'h3000_0000, 3'h1, 6'b000001);
    acc(3'h3, 32'h3000_0000, 3'h1, 6'b100000);
    $display("verdict test done");
    test_done();
  end
endmodule : region_protection_unit_test
